// *** i2cs_defines.vh ***
// constants for the two-wire slave state handling block
`ifndef I2CS_DEFINES_VH
`define I2CS_DEFINES_VH
// register offsets (byte addresses, 32-bit words)
`define I2CS_ADDR_CONSET 8'h00
`define I2CS_ADDR_STATUS 8'h04
`define I2CS_ADDR_DATA 8'h08
`define I2CS_ADDR_OWNADR 8'h0C
`define I2CS_ADDR_CONCLR 8'h18
`define I2CS_ADDR_IRQ_STAT 8'h20
`define I2CS_ADDR_IRQ_EN 8'h24
`define I2CS_ADDR_IRQ_CLR 8'h28
`define I2CS_ADDR_MSTCMD 8'h2C
// control bit positions
`define I2CS_CON_ACK 2
`define I2CS_CON_SI 3
`define I2CS_CON_STO 4
`define I2CS_CON_START 5
`define I2CS_CON_EN 6
`define I2CS_CON_RESET 7'h00
// status codes
`define I2CS_ST_IDLE 8'hF8
`define I2CS_ST_BUSERR 8'h00
`define I2CS_ST_SR_ADDR 8'h60
`define I2CS_ST_SR_ALOST 8'h68
`define I2CS_ST_GC_ADDR 8'h70
`define I2CS_ST_GC_ALOST 8'h78
`define I2CS_ST_SR_ACK 8'h80
`define I2CS_ST_SR_NACK 8'h88
`define I2CS_ST_GC_ACK 8'h90
`define I2CS_ST_GC_NACK 8'h98
`define I2CS_ST_STOP 8'hA0
`define I2CS_ST_ST_ADDR 8'hA8
`define I2CS_ST_ST_ALOST 8'hB0
`define I2CS_ST_ST_ACK 8'hB8
`define I2CS_ST_ST_NACK 8'hC0
`define I2CS_ST_ST_LAST 8'hC8
`define I2CS_ST_ALOST 8'h38
// interrupt event bits
`define I2CS_IRQ_SI 0
`define I2CS_IRQ_STOP 1
`define I2CS_IRQ_ALOST 2
`define I2CS_IRQ_W 3
// pin glitch filter length in ref_clk cycles
`define I2CS_FILT_LEN 3
`endif

// *** i2cs_pin_sync.v ***
// two-flop synchroniser with consecutive-sample hold filter for one bus pin
`timescale 1ns/1ps
module i2cs_pin_sync #(
  parameter FILT = 3
) (
  ref_clk,
  reset,
  pin_in,
  level_out
);
  input wire ref_clk;
  input wire reset;
  input wire pin_in;
  output reg level_out;

  reg meta_q;
  reg sync_q;
  reg [3:0] cnt_q;

  // ----------------------------------------------------------------
  // synchroniser, then a level must hold FILT+1 cycles to be accepted
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      cnt_q <= 4'h0;
      level_out <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      if (sync_q == level_out) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == FILT[3:0]) begin
        cnt_q <= 4'h0;
        level_out <= sync_q;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// *** i2cs_slave.v ***
// two-wire bus slave controller with status-code service states
// Operation
// - lost arbitration then own write: 0x68
// - general call acked, status 0x70
// - lost arbitration then general call: 0x78
// - own-address data acked, 0x80, readable
// - nacked own data: 0x88, discard, unaddress
// - general call data acked reports 0x90
// - general call data nacked: 0x98, unaddress
// - stop or restart while addressed as receiver (S_RX or S_RXACK): 0xA0
// - own address read: ack, 0xA8, transmit
// - lost arbitration then own read: 0xB0
// - sent byte acked by master: 0xB8
// - sent byte nacked by master: 0xC0
// - last byte acked by master: 0xC8
// - every service event loads status code
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "i2cs_defines.vh"
module i2cs_slave (
  ref_clk,
  reset,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  scl_in,
  scl_out,
  scl_oe,
  sda_in,
  sda_out,
  sda_oe,
  irq
);
  input wire ref_clk;
  input wire reset;
  input wire [7:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire scl_in;
  output wire scl_out;
  output wire scl_oe;
  input wire sda_in;
  output wire sda_out;
  output wire sda_oe;
  output wire irq;

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_RX = 3'd2;
  localparam S_RXACK = 3'd3;
  localparam S_TX = 3'd4;
  localparam S_TXACK = 3'd5;
  localparam S_WAIT = 3'd6;

  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;
  reg [6:0] con_q;
  reg [7:0] stat_q;
  reg [7:0] data_q;
  reg [7:0] own_q;
  reg [7:0] shift_q;
  reg [3:0] bit_q;
  reg [2:0] st_q;
  reg gc_q;
  reg ack_q;
  reg drive_q;
  reg last_q;
  reg mst_pend_q;
  reg [`I2CS_IRQ_W-1:0] irq_stat_q;
  reg [`I2CS_IRQ_W-1:0] irq_en_q;
  reg [7:0] rd_mux;

  i2cs_pin_sync #(.FILT(`I2CS_FILT_LEN)) u_scl (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in(scl_in),
    .level_out(scl_s)
  );
  i2cs_pin_sync #(.FILT(`I2CS_FILT_LEN)) u_sda (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in(sda_in),
    .level_out(sda_s)
  );

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire si = con_q[`I2CS_CON_SI];
  wire ack_en = con_q[`I2CS_CON_ACK];
  wire en = con_q[`I2CS_CON_EN];
  wire wr_set = reg_wr & (reg_addr == `I2CS_ADDR_CONSET);
  wire wr_clr = reg_wr & (reg_addr == `I2CS_ADDR_CONCLR);
  wire wr_data = reg_wr & (reg_addr == `I2CS_ADDR_DATA);
  // a master attempt that lost address arbitration; the master engine is
  // outside this block, so its loss is signalled by software command
  wire alost = mst_pend_q;

  // event strobe: raise flag and load status code
  reg ev;
  reg [7:0] ev_code;
  reg [2:0] st_d;

  // ------------------------------------------------------------
  // bus state machine
  // ------------------------------------------------------------
  always @* begin
    ev = 1'b0;
    ev_code = stat_q;
    st_d = st_q;
    if (stop_cond | start_cond) begin
      if (st_q != S_IDLE && st_q != S_ADDR && st_q != S_WAIT && st_q != S_TX && st_q != S_TXACK) begin
        ev = 1'b1;
        ev_code = `I2CS_ST_STOP;
      end
      st_d = start_cond ? S_ADDR : S_IDLE;
    end else if (scl_rise && st_q == S_RX && bit_q == 4'd8) begin
      st_d = S_RXACK;
    end else if (scl_fall && st_q == S_RXACK) begin
      st_d = S_WAIT;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      gc_q <= 1'b0;
      ack_q <= 1'b0;
      drive_q <= 1'b0;
      last_q <= 1'b0;
      con_q <= `I2CS_CON_RESET;
      stat_q <= `I2CS_ST_IDLE;
      data_q <= 8'h00;
      own_q <= 8'h00;
      mst_pend_q <= 1'b0;
      irq_stat_q <= {`I2CS_IRQ_W{1'b0}};
      irq_en_q <= {`I2CS_IRQ_W{1'b0}};
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      // control set/clear; hardware flag raise wins over clear
      if (wr_set) begin
        con_q <= con_q | reg_wdata[6:0];
      end else if (wr_clr) begin
        con_q <= con_q & ~reg_wdata[6:0];
      end
      if (wr_data) begin
        data_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `I2CS_ADDR_OWNADR) begin
        own_q <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == `I2CS_ADDR_MSTCMD) begin
        mst_pend_q <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == `I2CS_ADDR_IRQ_EN) begin
        irq_en_q <= reg_wdata[`I2CS_IRQ_W-1:0];
      end
      if (reg_wr && reg_addr == `I2CS_ADDR_IRQ_CLR) begin
        irq_stat_q <= irq_stat_q & ~reg_wdata[`I2CS_IRQ_W-1:0];
      end
      st_q <= st_d;
      if (!en) begin
        st_q <= S_IDLE;
        drive_q <= 1'b0;
      end else if (start_cond) begin
        bit_q <= 4'h0;
        gc_q <= 1'b0;
        drive_q <= 1'b0;
        if (ev) begin
          stat_q <= ev_code;
          con_q[`I2CS_CON_SI] <= 1'b1;
          irq_stat_q[`I2CS_IRQ_STOP] <= 1'b1;
        end
      end else if (stop_cond) begin
        drive_q <= 1'b0;
        gc_q <= 1'b0;
        if (ev) begin
          stat_q <= ev_code;
          con_q[`I2CS_CON_SI] <= 1'b1;
          irq_stat_q[`I2CS_IRQ_STOP] <= 1'b1;
        end
      end else begin
        case (st_q)
          S_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'd8) begin
              bit_q <= 4'h0;
              if (shift_q[7:1] == own_q[7:1] && ack_en && !si) begin
                drive_q <= 1'b1;
                data_q <= shift_q;
                st_q <= S_RXACK;
                gc_q <= 1'b0;
                ack_q <= ~shift_q[0];
              end else if (shift_q == 8'h00 && own_q[0] && ack_en && !si) begin
                drive_q <= 1'b1;
                st_q <= S_RXACK;
                gc_q <= 1'b1;
                ack_q <= 1'b1;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_RXACK: begin
            // first ack slot: our address; flag raised when slot ends
            if (scl_fall) begin
              drive_q <= 1'b0;
              irq_stat_q[`I2CS_IRQ_SI] <= 1'b1;
              con_q[`I2CS_CON_SI] <= 1'b1;
              if (bit_q == 4'd0) begin
                if (gc_q) begin
                  stat_q <= alost ? `I2CS_ST_GC_ALOST : `I2CS_ST_GC_ADDR;
                  st_q <= S_WAIT;
                end else if (data_q[0]) begin
                  stat_q <= alost ? `I2CS_ST_ST_ALOST : `I2CS_ST_ST_ADDR;
                  st_q <= S_WAIT;
                  last_q <= 1'b1;
                end else begin
                  stat_q <= alost ? `I2CS_ST_SR_ALOST : `I2CS_ST_SR_ADDR;
                  st_q <= S_WAIT;
                end
                if (alost) begin
                  irq_stat_q[`I2CS_IRQ_ALOST] <= 1'b1;
                  mst_pend_q <= 1'b0;
                end
              end else begin
                bit_q <= 4'h0;
                if (ack_q) begin
                  data_q <= shift_q;
                  stat_q <= gc_q ? `I2CS_ST_GC_ACK : `I2CS_ST_SR_ACK;
                  st_q <= S_WAIT;
                end else begin
                  // nack: byte discarded, not addressed any more
                  stat_q <= gc_q ? `I2CS_ST_GC_NACK : `I2CS_ST_SR_NACK;
                  st_q <= S_IDLE;
                  gc_q <= 1'b0;
                end
              end
            end
          end
          S_WAIT: begin
            // clock stretched low until software clears the flag
            if (!si) begin
              if (stat_q == `I2CS_ST_ST_ADDR || stat_q == `I2CS_ST_ST_ALOST ||
                  stat_q == `I2CS_ST_ST_ACK) begin
                shift_q <= data_q;
                last_q <= ~ack_en;
                st_q <= S_TX;
                drive_q <= ~data_q[7];
                bit_q <= 4'h0;
              end else if (stat_q == `I2CS_ST_ST_LAST || stat_q == `I2CS_ST_ST_NACK) begin
                st_q <= S_IDLE;
              end else begin
                st_q <= S_RX;
                bit_q <= 4'h0;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == 4'd8) begin
              ack_q <= ack_en;
              drive_q <= ack_en;
              st_q <= S_RXACK;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              bit_q <= bit_q + 4'h1;
              shift_q <= {shift_q[6:0], 1'b1};
              drive_q <= (bit_q == 4'd7) ? 1'b0 : ~shift_q[6];
              if (bit_q == 4'd7) begin
                st_q <= S_TXACK;
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              con_q[`I2CS_CON_SI] <= 1'b1;
              irq_stat_q[`I2CS_IRQ_SI] <= 1'b1;
              st_q <= S_WAIT;
              if (sda_s) begin
                stat_q <= `I2CS_ST_ST_NACK;
              end else if (last_q) begin
                stat_q <= `I2CS_ST_ST_LAST;
              end else begin
                stat_q <= `I2CS_ST_ST_ACK;
              end
            end
          end
          default: begin
            bit_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pins and register read
  // ------------------------------------------------------------
  // clock held low while a service state waits on software
  assign scl_out = 1'b0;
  assign scl_oe = si & (st_q == S_WAIT) & ~scl_s;
  assign sda_out = 1'b0;
  assign sda_oe = drive_q;
  assign irq = |(irq_stat_q & irq_en_q);

  always @* begin
    case (reg_addr)
      `I2CS_ADDR_CONSET: rd_mux = {1'b0, con_q};
      `I2CS_ADDR_STATUS: rd_mux = stat_q;
      `I2CS_ADDR_DATA: rd_mux = data_q;
      `I2CS_ADDR_OWNADR: rd_mux = own_q;
      `I2CS_ADDR_IRQ_STAT: rd_mux = {4'h0, 1'b0, irq_stat_q};
      `I2CS_ADDR_IRQ_EN: rd_mux = {4'h0, 1'b0, irq_en_q};
      `I2CS_ADDR_MSTCMD: rd_mux = {7'h00, mst_pend_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end
endmodule

// *** i2cs_slave_sva.sv ***
// checker for the two-wire slave block ports
`timescale 1ns/1ps
`include "i2cs_defines.vh"
module i2cs_slave_sva (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire scl_oe,
  input wire sda_oe,
  input wire irq
);
  // ----------------------------------------
  // interrupt enable shadow and properties
  // ----------------------------------------
  reg [3:0] en_q;
  always @(posedge ref_clk) begin
    if (reset)
      en_q <= 4'h0;
    else if (reg_wr && reg_addr == `I2CS_ADDR_IRQ_EN)
      en_q <= reg_wdata[3:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_set_rd;
    reg_wr && reg_addr == `I2CS_ADDR_CONSET ##2 reg_rd && reg_addr == `I2CS_ADDR_CONSET;
  endsequence
  sequence s_clr_rd;
    reg_wr && reg_addr == `I2CS_ADDR_CONCLR ##2 reg_rd && reg_addr == `I2CS_ADDR_CONSET;
  endsequence
  a_set_bits: assert property (
    s_set_rd |=> (reg_rdata[6:0] & $past(reg_wdata[6:0], 3) & 7'h44) == ($past(reg_wdata[6:0], 3) & 7'h44))
    else $error("set write lost bits");
  a_clr_bits: assert property (
    s_clr_rd |=> (reg_rdata[6:0] & $past(reg_wdata[6:0], 3) & 7'h44) == 7'h0)
    else $error("clear write left bits");
  a_status_form: assert property (
    $past(reg_rd) && $past(reg_addr) == `I2CS_ADDR_STATUS |-> reg_rdata[31:8] == 24'h0 && reg_rdata[2:0] == 3'h0)
    else $error("status code malformed");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_mask: assert property (irq |-> en_q != 4'h0)
    else $error("irq while masked");
  a_scl_release: assert property (
    reg_wr && reg_addr == `I2CS_ADDR_CONCLR && reg_wdata[`I2CS_CON_SI] && scl_oe |-> ##[1:3] !scl_oe)
    else $error("clock not released");
  a_reset_quiet: assert property ($fell(reset) |-> !scl_oe && !sda_oe && !irq)
    else $error("outputs active after reset");
endmodule
bind i2cs_slave i2cs_slave_sva chk_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .irq(irq));

// *** i2cs_bus_master.sv ***
// bus master model driving the two-wire slave
`timescale 1ns/1ps
module i2cs_bus_master (
  input wire scl_line,
  input wire sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  // ----------------------------------------
  // bit slot, framing and byte tasks
  // ----------------------------------------
  // drv high pulls the line low; a released line rises by its pull-up
  initial begin
    scl_drv = 1'h0;
    sda_drv = 1'h0;
  end
  task automatic slot(input logic b, output logic s);
    sda_drv = ~b;
    #40;
    scl_drv = 1'h0;
    // the slave may stretch the low phase, so follow the wire itself
    wait (scl_line === 1'h1);
    #80;
    s = sda_line;
    scl_drv = 1'h1;
    #40;
  endtask
  task automatic start_c;
    sda_drv = 1'h1;
    #80;
    scl_drv = 1'h1;
    #40;
  endtask
  task automatic stop_c;
    sda_drv = 1'h1;
    #40;
    scl_drv = 1'h0;
    wait (scl_line === 1'h1);
    #80;
    sda_drv = 1'h0;
    #160;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'h1, s);
    ack = ~s;
  endtask
  task automatic get_byte(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'h1, b[i]);
    slot(~ack, s);
  endtask
endmodule

// *** i2c_slave_state_handling_tb_top.sv ***
// self-checking bench for the two-wire slave block
`timescale 1ns/1ps
`include "i2cs_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_slave_state_handling_tb_top;
  reg ref_clk = 1'h0;
  reg reset = 1'h1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'h0;
  reg reg_rd = 1'h0;
  wire [31:0] reg_rdata;
  wire scl_oe;
  wire sda_oe;
  wire m_scl;
  wire m_sda;
  wire irq;
  wire scl_w = ~(scl_oe | m_scl);
  wire sda_w = ~(sda_oe | m_sda);
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  i2cs_slave dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .irq(irq));
  i2cs_bus_master m_u (.scl_line(scl_w), .sda_line(sda_w), .scl_drv(m_scl), .sda_drv(m_sda));
  // ----------------------------------------
  // register bus and service tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
  task automatic srv(input logic [7:0] code, input logic [31:0] setv, input logic [31:0] clrv,
    input logic [7:0] txd, output logic [7:0] d);
    logic [31:0] v;
    for (int i = 0; i < 4000 && irq !== 1'h1; i++) @(posedge ref_clk);
    `CHK(irq, 1'h1)
    rd(`I2CS_ADDR_STATUS, v);
    `CHK(v[7:0], code)
    rd(`I2CS_ADDR_DATA, v);
    d = v[7:0];
    wr(`I2CS_ADDR_DATA, {24'h0, txd});
    wr(`I2CS_ADDR_IRQ_CLR, 32'h7);
    wr(`I2CS_ADDR_CONSET, setv);
    wr(`I2CS_ADDR_CONCLR, clrv);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] v;
    rd(`I2CS_ADDR_STATUS, v);
    `CHK(v[7:0], 8'hF8)
    wr(`I2CS_ADDR_OWNADR, 32'h55);
    wr(`I2CS_ADDR_CONSET, 32'h44);
    rd(`I2CS_ADDR_CONSET, v);
    `CHK(v[6:0], 7'h44)
    wr(`I2CS_ADDR_CONCLR, 32'h04);
    rd(`I2CS_ADDR_CONSET, v);
    `CHK(v[6:0], 7'h40)
    wr(`I2CS_ADDR_CONSET, 32'h04);
    rd(8'h10, v);
    `CHK(v, 32'h0)
  endtask
  task automatic t_rx;
    logic [7:0] d;
    logic a;
    logic [31:0] v;
    wr(`I2CS_ADDR_IRQ_EN, 32'h0);
    m_u.start_c;
    m_u.send_byte(8'h54, a);
    `CHK(a, 1'h1)
    v = 32'h0;
    for (int i = 0; i < 100 && v[0] !== 1'h1; i++) rd(`I2CS_ADDR_IRQ_STAT, v);
    `CHK(irq, 1'h0)
    wr(`I2CS_ADDR_IRQ_EN, 32'h7);
    @(negedge ref_clk);
    srv(8'h60, 32'h04, 32'h08, 8'h00, d);
    m_u.send_byte(8'hA5, a);
    srv(8'h80, 32'h0, 32'h0C, 8'h00, d);
    `CHK(d, 8'hA5)
    m_u.send_byte(8'h5A, a);
    `CHK(a, 1'h0)
    srv(8'h88, 32'h04, 32'h08, 8'h00, d);
    `CHK(d, 8'h00)
    m_u.stop_c;
  endtask
  task automatic t_gc;
    logic [7:0] d;
    logic a;
    m_u.start_c;
    m_u.send_byte(8'h00, a);
    srv(8'h70, 32'h04, 32'h08, 8'h00, d);
    m_u.send_byte(8'h3C, a);
    srv(8'h90, 32'h0, 32'h0C, 8'h00, d);
    `CHK(d, 8'h3C)
    m_u.send_byte(8'hC3, a);
    `CHK(a, 1'h0)
    srv(8'h98, 32'h04, 32'h08, 8'h00, d);
    `CHK(d, 8'h00)
    m_u.stop_c;
  endtask
  task automatic t_alost;
    logic [7:0] d;
    logic a;
    wr(`I2CS_ADDR_MSTCMD, 32'h1);
    m_u.start_c;
    m_u.send_byte(8'h54, a);
    srv(8'h68, 32'h24, 32'h08, 8'h00, d);
    m_u.stop_c;
    srv(8'hA0, 32'h04, 32'h28, 8'h00, d);
    `CHK(d, 8'h00)
    wr(`I2CS_ADDR_MSTCMD, 32'h1);
    m_u.start_c;
    m_u.send_byte(8'h00, a);
    srv(8'h78, 32'h24, 32'h08, 8'h00, d);
    m_u.stop_c;
    srv(8'hA0, 32'h04, 32'h28, 8'h00, d);
    `CHK(d, 8'h00)
    wr(`I2CS_ADDR_MSTCMD, 32'h0);
  endtask
  task automatic t_tx;
    logic [7:0] d;
    logic a;
    m_u.start_c;
    m_u.send_byte(8'h55, a);
    srv(8'hA8, 32'h04, 32'h08, 8'h69, d);
    m_u.get_byte(d, 1'h1);
    `CHK(d, 8'h69)
    srv(8'hB8, 32'h0, 32'h0C, 8'h96, d);
    m_u.get_byte(d, 1'h1);
    `CHK(d, 8'h96)
    srv(8'hC8, 32'h04, 32'h08, 8'h00, d);
    m_u.stop_c;
    wr(`I2CS_ADDR_MSTCMD, 32'h1);
    m_u.start_c;
    m_u.send_byte(8'h55, a);
    srv(8'hB0, 32'h24, 32'h08, 8'hF0, d);
    m_u.get_byte(d, 1'h0);
    `CHK(d, 8'hF0)
    srv(8'hC0, 32'h04, 32'h28, 8'h00, d);
    m_u.stop_c;
    wr(`I2CS_ADDR_MSTCMD, 32'h0);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hung clock stretch would otherwise stall the run forever
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    t_regs;
    t_rx;
    t_gc;
    t_alost;
    t_tx;
    print_verdict;
  end
endmodule
